// file: hw/sdl_pkg.sv
package sdl_pkg;

  // ----------------------------------------------------------------------
  // word format
  // ----------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MID_CODE  = 16'h8000;
  localparam logic [1:0]  SYNC_RST  = 2'h0;
  localparam logic [1:0]  SYNC_SET  = 2'h3;
  localparam logic [4:0]  COUNT_RST = 5'h00;

  // ----------------------------------------------------------------------
  // variant selection
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SDL_ZERO_SCALE = 2'h1,
    SDL_MID_SCALE  = 2'h2
  } sdl_variant_t;

endpackage

// file: hw/sdl_latch.sv
// Summary of operation
// - shifting happens only while chip select is low
// - chip select rising edge copies the 16-bit shift word into the latch
// - data input is sampled on each serial clock rising edge while chip select is low
// - zero-scale variant, clear low forces latch to code 0 three clock edges later, through the synchroniser
// - midscale variant, clear low forces latch to midscale code
// - most significant bit shifted first, first bit ends as bit 15
// - extra edges keep last 16 bits; fewer give corrupt word
// - reset loads zero or midscale according to variant
`timescale 1ns/100ps

module sdl_latch
  import sdl_pkg::*;
#(
  parameter sdl_variant_t VARIANT = sdl_pkg::SDL_ZERO_SCALE
)
(
  input  wire logic                      CLOCK,           // system clock 25 MHz
  input  wire logic                      SYS_RST,         // async reset, high
  input  wire logic                      SCLK_PIN,        // serial clock pin
  input  wire logic                      CS_N,            // chip select, low
  input  wire logic                      DATA_IN,         // serial data pin
  input  wire logic                      ASYNC_CLEAR_N,   // clear, low
  output logic [sdl_pkg::WORD_W-1:0]     DAC_CODE         // latch to converter
);

  import sdl_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] sync_sclk;
  logic [1:0] sync_cs;
  logic [1:0] sync_din;
  logic [1:0] sync_clr;
  logic       sclk_q;
  logic       cs_q;
  logic [WORD_W-1:0] shift;
  logic [WORD_W-1:0] next_shift;
  logic [WORD_W-1:0] next_code;

  localparam logic [WORD_W-1:0] CLEAR_CODE =
    (VARIANT == SDL_MID_SCALE) ? MID_CODE : ZERO_CODE;

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sync_sclk <= SYNC_RST;
      // select and clear idle high: reset them high, no false edge
      sync_cs   <= SYNC_SET;
      sync_din  <= SYNC_RST;
      sync_clr  <= SYNC_SET;
    end
    else
    begin
      sync_sclk <= {sync_sclk[0], SCLK_PIN};
      sync_cs   <= {sync_cs[0], CS_N};
      sync_din  <= {sync_din[0], DATA_IN};
      sync_clr  <= {sync_clr[0], ASYNC_CLEAR_N};
    end
  end

  // ----------------------------------------------------------------------
  // edge detection and decode
  // ----------------------------------------------------------------------
  wire sclk_rise = sync_sclk[1] & ~sclk_q;
  wire cs_rise   = sync_cs[1] & ~cs_q;
  wire cs_fall   = ~sync_cs[1] & cs_q;
  wire selected  = ~sync_cs[1];
  wire shift_en  = selected & sclk_rise;
  wire clearing  = ~sync_clr[1];

  assign next_shift = shift_en ?
    {shift[WORD_W-2:0], sync_din[1]} : shift;

  assign next_code = clearing ? CLEAR_CODE :
                     cs_rise  ? shift :
                     DAC_CODE;

  // ----------------------------------------------------------------------
  // shift register and latch
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      shift    <= ZERO_CODE;
      DAC_CODE <= CLEAR_CODE;
    end
    else
    begin
      sclk_q   <= sync_sclk[1];
      cs_q     <= sync_cs[1];
      shift    <= next_shift;
      DAC_CODE <= next_code;
    end
  end

  // ----------------------------------------------------------------------
  // frame bit counter
  // ----------------------------------------------------------------------
  // counts serial clock rises in a frame, saturating at the word width;
  // only the checks read it, the datapath does not depend on it
  logic [4:0] bit_count;
  logic [4:0] next_bit_count;

  wire count_full = (bit_count == 5'(WORD_W));
  wire count_step = shift_en & ~count_full;

  assign next_bit_count = cs_fall    ? COUNT_RST :
                          count_step ? bit_count + 5'h01 :
                          bit_count;

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      bit_count <= COUNT_RST;
    end
    else
    begin
      bit_count <= next_bit_count;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_shift_gated: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    sync_cs[1] |=> shift == $past(shift))
    else $error("shift changed while deselected");

  chk_load_word: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (cs_rise && !clearing) |=> DAC_CODE == $past(shift))
    else $error("latch not loaded on select release");

  chk_sample_bit: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    shift_en |=> shift[0] == $past(sync_din[1]))
    else $error("data bit not sampled");

  chk_msb_order: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    shift_en |=> shift[WORD_W-1:1] == $past(shift[WORD_W-2:0]))
    else $error("shift order wrong");

  chk_clear_zero: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (clearing && VARIANT == SDL_ZERO_SCALE) |=> DAC_CODE == 16'h0000)
    else $error("clear did not give zero");

  chk_clear_mid: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (clearing && VARIANT == SDL_MID_SCALE) |=> DAC_CODE == 16'h8000)
    else $error("clear did not give midscale");

  chk_hold_code: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (!clearing && !cs_rise) |=> $stable(DAC_CODE))
    else $error("latch changed without cause");

  chk_last_bits: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (shift_en ##1 !shift_en) |-> shift[0] == $past(sync_din[1]))
    else $error("last bit not kept");

  chk_reset_code: assert property (
    @(posedge CLOCK)
    $fell(SYS_RST) |-> DAC_CODE == CLEAR_CODE || clearing)
    else $error("reset code wrong");

  // a clear and a load in one cycle: the clear must win
  chk_clear_wins: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (clearing && cs_rise) |=> DAC_CODE == CLEAR_CODE)
    else $error("load beat a pending clear");

  chk_shift_idle: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (selected && !sclk_rise) |=> $stable(shift))
    else $error("shift moved without a clock rise");

  chk_load_once: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    cs_rise |=> !cs_rise)
    else $error("select release seen twice");

  chk_reset_shift: assert property (
    @(posedge CLOCK)
    $fell(SYS_RST) |-> shift == ZERO_CODE)
    else $error("shift word not cleared by reset");

  chk_count_limit: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    bit_count <= 5'(WORD_W))
    else $error("bit count beyond word width");

  chk_count_start: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    cs_fall |=> bit_count == COUNT_RST)
    else $error("bit count not restarted by select");

  chk_code_cause: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    !$stable(DAC_CODE) |-> $past(clearing || cs_rise))
    else $error("latch moved with no load or clear");

  chk_idle_count: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    sync_cs[1] |=> $stable(bit_count))
    else $error("clock rise counted while deselected");

endmodule // sdl_latch

// file: tb/sdl_host.sv
`timescale 1ns/100ps
module sdl_host
(
  input  wire logic clk,  // bench clock
  output logic      sclk, // serial clock
  output logic      cs_n, // chip select, low
  output logic      din   // serial data
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // sends the low n bits of w, msb first; sclk period is 8 clk
  task send(input logic [31:0] w, input int n);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    din  <= ~din;
    repeat (6) @(posedge clk);
  endtask
  // serial clock pulses with select high; the device must ignore them
  task stray(input int n);
    for (int i = 0; i < n; i++)
    begin
      din <= ~din;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
endmodule // sdl_host

// file: tb/sdl_latch_test.sv
`timescale 1ns/100ps
module sdl_latch_test;
  import sdl_pkg::*;
  logic        CLOCK, SYS_RST, clr_n, sclk, cs_n, din;
  logic [15:0] code_z, code_m, lfsr, prev;
  int          n_errors, check_count;
  sdl_host host (.clk(CLOCK), .sclk(sclk), .cs_n(cs_n), .din(din));
  sdl_latch #(.VARIANT(SDL_ZERO_SCALE)) dut (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .SCLK_PIN(sclk), .CS_N(cs_n), .DATA_IN(din),
    .ASYNC_CLEAR_N(clr_n), .DAC_CODE(code_z));
  sdl_latch #(.VARIANT(SDL_MID_SCALE)) dut_mid (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .SCLK_PIN(sclk), .CS_N(cs_n), .DATA_IN(din),
    .ASYNC_CLEAR_N(clr_n), .DAC_CODE(code_m));
  function logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // an 8-bit frame keeps the old low byte above the new bits
  function logic [15:0] short_word(input logic [15:0] old,
                                   input logic [7:0] tail);
    return {old[7:0], tail};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want)
    begin
      n_errors++;
      $display("BAD %0t code %h want %h", $time, got, want);
    end
  endtask
  task final_report();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  initial
  begin
    #2000000;
    n_errors++;
    final_report();
  end
  initial
  begin
    SYS_RST = 1'b1;
    clr_n = 1'b1;
    lfsr = 16'h0010;
    repeat (12) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    repeat (3) @(posedge CLOCK);
    chk(code_z, 16'h0000);
    chk(code_m, 16'h8000);
    for (int i = 0; i < 10; i++)
    begin
      lfsr = nxt(lfsr);
      host.send({lfsr, ~lfsr}, (i > 6) ? 16 + i : 16);
      chk(code_z, ~lfsr);
      chk(code_m, ~lfsr);
      if (i == 4)
      begin
        clr_n <= 1'b0;
        repeat (5) @(posedge CLOCK);
        chk(code_z, 16'h0000);
        chk(code_m, 16'h8000);
        clr_n <= 1'b1;
        repeat (3) @(posedge CLOCK);
      end
    end
    lfsr = nxt(lfsr);
    host.send({lfsr, lfsr}, 16);
    host.stray(5);
    chk(code_z, lfsr);
    prev = lfsr;
    lfsr = nxt(lfsr);
    host.send({16'h0000, lfsr}, 8);
    chk(code_m, short_word(prev, lfsr[7:0]));
    final_report();
  end
endmodule // sdl_latch_test
